/* shared/csbs_pkg.sv */
// Constants, codes and step encodings of the context switch bus sequencer.
// Assumes one machine cycle per clock edge and 16-bit byte-addressed words.
package csbs_pkg;

	// ----------------
	// Bus status codes
	// ----------------
	localparam logic [3:0] VECTOR_READ_CODE = 4'h5;
	localparam logic [3:0] WORKSPACE_ACCESS_CODE = 4'h6;
	localparam logic [3:0] OPCODE_FETCH_CODE = 4'h3;
	localparam logic [3:0] INTERNAL_CYCLE_CODE = 4'h9;
	localparam logic [3:0] POINTER_OUT_CODE = 4'hc;
	localparam logic [3:0] STATUS_OUT_CODE = 4'hd;
	localparam logic [3:0] PRESENCE_CHECK_CODE = 4'he;
	localparam logic [3:0] BUS_GRANT_CODE = 4'hf;

	// ----------------
	// Workspace slots and reset values
	// ----------------
	localparam logic [3:0] SAVED_POINTER_SLOT = 4'hd;
	localparam logic [3:0] SAVED_COUNTER_SLOT = 4'he;
	localparam logic [3:0] SAVED_STATUS_SLOT = 4'hf;
	localparam logic [3:0] IR_COPY_SLOT = 4'h5;
	localparam logic [3:0] PREFIX_SLOT = 4'h3;
	localparam logic [15:0] RST_WORD = 16'h0000;
	localparam logic [15:0] ZERO_ADDR = 16'h0000;
	localparam logic [15:0] WORD_STEP = 16'h0002;
	localparam logic [3:0] IDX_ZERO = 4'h0;
	localparam logic [3:0] IDX_ONE = 4'h1;
	localparam logic [3:0] TRAP_LEN = 4'h2;

	// ----------------
	// Sequencer states, Gray coded along the usual path
	// ----------------
	typedef enum logic [2:0] {
		CSBS_IDLE = 3'b000,
		CSBS_TRAP = 3'b001,
		CSBS_XFER = 3'b011,
		CSBS_HOLD = 3'b010,
		CSBS_RESUME = 3'b110,
		CSBS_MACRO = 3'b111,
		CSBS_INT = 3'b101
	} csbs_state_e;

	// ----------------
	// Per-cycle actions
	// ----------------
	typedef enum logic [4:0] {
		OP_NONE, OP_ZERO, OP_VWP, OP_VPC, OP_SWP, OP_W13, OP_W14, OP_W15,
		OP_FET, OP_R14, OP_R15, OP_R13, OP_SST, OP_IIR, OP_IPC2, OP_IWR3,
		OP_IVEC, OP_I13, OP_I14, OP_I15
	} csbs_op_e;

	typedef struct packed {
		logic [3:0] code;
		csbs_op_e op;
		logic last;
	} csbs_step_s;

endpackage : csbs_pkg

/* hw/csbs_sequencer.sv */
// Bus-cycle sequencer for interrupt entry, unimplemented-opcode trap and
// hand-over of the bus to an attached processor, with the way back.
// Assumes the core holds its request and trap inputs stable while busy_o.
//
// Summary of operation
// - Interrupt: two internal, then zero-address status cycle
// - Then vector read loads new workspace pointer
// - Two internal, then vector read loads counter
// - Show pointer, save three slots, fetch, internal
// - Trap: internal cycle, then presence check cycle
// - Internal trap copies instruction register to slot5
// - Second-word trap stores counter minus two
// - Prefix flags and first word into slot3
// - Internal vector read; only internal code shown
// - Save user context internally, two internal cycles
// - Attached: two internal, zero-address, level-2 vector read
// - Three internal, show pointer, save three slots
// - Then hold-acknowledge cycles, bus released
// - On return, one final hold-acknowledge cycle
// - Read counter, status, pointer from workspace
// - Show status, fetch opcode, show pointer
module csbs_sequencer #(
	parameter int WORD_W = 16,
	parameter logic [15:0] L2_VEC_ADDR = 16'h0008
) (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic arst_n_i,
	// Requests from the core
	input wire logic int_req_i,
	input wire logic trap_req_i,
	input wire logic trap_second_word_i,
	input wire logic attached_present_i,
	input wire logic hold_return_i,
	// Core context and trap data
	input wire logic ctx_load_i,
	input wire logic [15:0] ctx_wp_i,
	input wire logic [15:0] ctx_pc_i,
	input wire logic [15:0] ctx_st_i,
	input wire logic [15:0] vec_addr_i,
	input wire logic [15:0] instruction_register_i,
	input wire logic [15:0] first_word_i,
	input wire logic long_source_flag_i,
	input wire logic long_dest_flag_i,
	input wire logic [15:0] macro_vec_pc_i,
	// External bus
	input wire logic [15:0] data_in_i,
	output logic [3:0] bus_status_o,
	output logic [15:0] addr_o,
	output logic [15:0] data_out_o,
	output logic rd_o,
	output logic wr_o,
	output logic bus_grant_o,
	// Internal workspace write port
	output logic iws_we_o,
	output logic [3:0] iws_idx_o,
	output logic [15:0] iws_data_o,
	output logic [1:0] iws_flags_o,
	// Context and progress
	output logic busy_o,
	output logic [15:0] wp_o,
	output logic [15:0] pc_o,
	output logic [15:0] st_o
);

	// ----------------
	// Elaboration check
	// ----------------
	generate
		if (WORD_W != 16) begin : g_bad_width
			$error("csbs_sequencer supports only a 16-bit word");
		end
	endgenerate

	// ----------------
	// Helpers
	// ----------------
	function automatic logic [15:0] ws_addr(input logic [15:0] wp, input logic [3:0] n);
		ws_addr = wp + {11'h000, n, 1'b0};
	endfunction : ws_addr

	function automatic csbs_pkg::csbs_step_s mk(input logic [3:0] c,
			input csbs_pkg::csbs_op_e o, input logic l);
		mk.code = c;
		mk.op = o;
		mk.last = l;
	endfunction : mk

	// The whole cycle script of every sequence lives in this one table
	function automatic csbs_pkg::csbs_step_s step_of(input csbs_pkg::csbs_state_e s,
			input logic [3:0] i);
		logic [3:0] ic;
		logic [3:0] vr;
		logic [3:0] wa;
		ic = csbs_pkg::INTERNAL_CYCLE_CODE;
		vr = csbs_pkg::VECTOR_READ_CODE;
		wa = csbs_pkg::WORKSPACE_ACCESS_CODE;
		step_of = mk(ic, csbs_pkg::OP_NONE, 1'b0);
		case (s)
			csbs_pkg::CSBS_INT: begin
				case (i)
					4'h2: step_of = mk(csbs_pkg::STATUS_OUT_CODE, csbs_pkg::OP_ZERO, 1'b0);
					4'h3: step_of = mk(vr, csbs_pkg::OP_VWP, 1'b0);
					4'h6: step_of = mk(vr, csbs_pkg::OP_VPC, 1'b0);
					4'h7: step_of = mk(csbs_pkg::POINTER_OUT_CODE, csbs_pkg::OP_SWP, 1'b0);
					4'h8: step_of = mk(wa, csbs_pkg::OP_W13, 1'b0);
					4'h9: step_of = mk(wa, csbs_pkg::OP_W14, 1'b0);
					4'ha: step_of = mk(wa, csbs_pkg::OP_W15, 1'b0);
					4'hb: step_of = mk(csbs_pkg::OPCODE_FETCH_CODE, csbs_pkg::OP_FET, 1'b0);
					4'hc: step_of = mk(ic, csbs_pkg::OP_NONE, 1'b1);
					default: step_of = mk(ic, csbs_pkg::OP_NONE, 1'b0);
				endcase
			end
			csbs_pkg::CSBS_TRAP: begin
				// presence check follows one internal cycle
				if (i == csbs_pkg::IDX_ONE) begin
					step_of = mk(csbs_pkg::PRESENCE_CHECK_CODE, csbs_pkg::OP_NONE, 1'b0);
				end
			end
			csbs_pkg::CSBS_MACRO: begin
				// every cycle shows the internal code
				case (i)
					4'h1: step_of = mk(ic, csbs_pkg::OP_IIR, 1'b0);
					4'h3: step_of = mk(ic, csbs_pkg::OP_IPC2, 1'b0);
					4'h4: step_of = mk(ic, csbs_pkg::OP_IWR3, 1'b0);
					4'h5: step_of = mk(ic, csbs_pkg::OP_IVEC, 1'b0);
					4'h7: step_of = mk(ic, csbs_pkg::OP_I13, 1'b0);
					4'h8: step_of = mk(ic, csbs_pkg::OP_I14, 1'b0);
					4'h9: step_of = mk(ic, csbs_pkg::OP_I15, 1'b0);
					4'hb: step_of = mk(ic, csbs_pkg::OP_NONE, 1'b1);
					default: step_of = mk(ic, csbs_pkg::OP_NONE, 1'b0);
				endcase
			end
			csbs_pkg::CSBS_XFER: begin
				case (i)
					4'h2: step_of = mk(csbs_pkg::STATUS_OUT_CODE, csbs_pkg::OP_ZERO, 1'b0);
					4'h3: step_of = mk(vr, csbs_pkg::OP_VWP, 1'b0);
					4'h7: step_of = mk(csbs_pkg::POINTER_OUT_CODE, csbs_pkg::OP_SWP, 1'b0);
					4'h8: step_of = mk(wa, csbs_pkg::OP_W13, 1'b0);
					4'h9: step_of = mk(wa, csbs_pkg::OP_W14, 1'b0);
					4'ha: step_of = mk(wa, csbs_pkg::OP_W15, 1'b0);
					4'hb: step_of = mk(csbs_pkg::BUS_GRANT_CODE, csbs_pkg::OP_NONE, 1'b1);
					default: step_of = mk(ic, csbs_pkg::OP_NONE, 1'b0);
				endcase
			end
			csbs_pkg::CSBS_HOLD: begin
				step_of = mk(csbs_pkg::BUS_GRANT_CODE, csbs_pkg::OP_NONE, 1'b0);
			end
			csbs_pkg::CSBS_RESUME: begin
				case (i)
					4'h0: step_of = mk(csbs_pkg::BUS_GRANT_CODE, csbs_pkg::OP_NONE, 1'b0);
					4'h1: step_of = mk(wa, csbs_pkg::OP_R14, 1'b0);
					4'h2: step_of = mk(wa, csbs_pkg::OP_R15, 1'b0);
					4'h3: step_of = mk(wa, csbs_pkg::OP_R13, 1'b0);
					4'h4: step_of = mk(csbs_pkg::STATUS_OUT_CODE, csbs_pkg::OP_SST, 1'b0);
					4'h5: step_of = mk(csbs_pkg::OPCODE_FETCH_CODE, csbs_pkg::OP_FET, 1'b0);
					default: step_of = mk(csbs_pkg::POINTER_OUT_CODE, csbs_pkg::OP_SWP, 1'b1);
				endcase
			end
			default: step_of = mk(ic, csbs_pkg::OP_NONE, 1'b0);
		endcase
	endfunction : step_of

	// ----------------
	// Reset release
	// ----------------
	logic rst_meta_ff;
	logic rst_n_ff;

	always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rst_meta_ff <= 1'b0;
			rst_n_ff <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_n_ff <= rst_meta_ff;
		end
	end

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	csbs_pkg::csbs_state_e state_ff;
	csbs_pkg::csbs_state_e eff_state;
	csbs_pkg::csbs_state_e nxt_state;
	csbs_pkg::csbs_step_s stp;
	csbs_pkg::csbs_op_e cap_ff;
	logic [3:0] idx_ff;
	logic [3:0] eff_idx;
	logic [3:0] nxt_idx;
	logic idle_w;
	logic start_w;
	logic branch_w;

	assign idle_w = (state_ff == csbs_pkg::CSBS_IDLE);
	// Presence is sampled in the cycle that shows the check code
	assign branch_w = (state_ff == csbs_pkg::CSBS_TRAP) && (idx_ff == csbs_pkg::TRAP_LEN);

	always_comb begin
		eff_state = state_ff;
		if (idle_w) begin
			// Trap wins: it belongs to the instruction already under way
			if (trap_req_i) begin
				eff_state = csbs_pkg::CSBS_TRAP;
			end else if (int_req_i) begin
				eff_state = csbs_pkg::CSBS_INT;
			end
		end else if (branch_w) begin
			eff_state = attached_present_i ? csbs_pkg::CSBS_XFER : csbs_pkg::CSBS_MACRO;
		end else if (state_ff == csbs_pkg::CSBS_HOLD && hold_return_i) begin
			eff_state = csbs_pkg::CSBS_RESUME;
		end
	end

	assign start_w = idle_w && (eff_state != csbs_pkg::CSBS_IDLE);
	assign eff_idx = (eff_state != state_ff) ? csbs_pkg::IDX_ZERO : idx_ff;
	assign stp = step_of(eff_state, eff_idx);

	always_comb begin
		nxt_state = eff_state;
		nxt_idx = eff_idx + csbs_pkg::IDX_ONE;
		if (eff_state == csbs_pkg::CSBS_IDLE || eff_state == csbs_pkg::CSBS_HOLD) begin
			nxt_idx = csbs_pkg::IDX_ZERO;
		end else if (stp.last) begin
			nxt_idx = csbs_pkg::IDX_ZERO;
			nxt_state = (eff_state == csbs_pkg::CSBS_XFER) ? csbs_pkg::CSBS_HOLD
					: csbs_pkg::CSBS_IDLE;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			state_ff <= csbs_pkg::CSBS_IDLE;
			idx_ff <= csbs_pkg::IDX_ZERO;
		end else begin
			state_ff <= nxt_state;
			idx_ff <= nxt_idx;
		end
	end

	// ----------------------------------------------------------------
	// Cycle decode
	// ----------------------------------------------------------------
	logic [15:0] wp_ff;
	logic [15:0] pc_ff;
	logic [15:0] st_ff;
	logic [15:0] old_wp_ff;
	logic [15:0] old_pc_ff;
	logic [15:0] old_st_ff;
	logic [15:0] vec_base;
	logic [15:0] nxt_addr;
	logic [15:0] nxt_dout;
	logic is_rd;
	logic is_wr;
	logic is_iws;
	logic [3:0] nxt_iws_idx;
	logic [15:0] nxt_iws_data;

	// attached hand-over uses the level-2 vector
	assign vec_base = (eff_state == csbs_pkg::CSBS_XFER) ? L2_VEC_ADDR : vec_addr_i;
	assign is_rd = stp.op inside {csbs_pkg::OP_VWP, csbs_pkg::OP_VPC, csbs_pkg::OP_FET,
			csbs_pkg::OP_R13, csbs_pkg::OP_R14, csbs_pkg::OP_R15};
	assign is_wr = stp.op inside {csbs_pkg::OP_W13, csbs_pkg::OP_W14, csbs_pkg::OP_W15};
	assign is_iws = stp.op inside {csbs_pkg::OP_IIR, csbs_pkg::OP_IWR3, csbs_pkg::OP_I13,
			csbs_pkg::OP_I14, csbs_pkg::OP_I15}
			|| (stp.op == csbs_pkg::OP_IPC2 && trap_second_word_i);

	always_comb begin
		nxt_addr = csbs_pkg::ZERO_ADDR;
		nxt_dout = csbs_pkg::RST_WORD;
		case (stp.op)
			csbs_pkg::OP_VWP: nxt_addr = vec_base;
			csbs_pkg::OP_VPC: nxt_addr = vec_base + csbs_pkg::WORD_STEP;
			csbs_pkg::OP_SWP: nxt_addr = wp_ff;
			csbs_pkg::OP_FET: nxt_addr = pc_ff;
			csbs_pkg::OP_SST: nxt_addr = st_ff;
			csbs_pkg::OP_W13, csbs_pkg::OP_R13: nxt_addr = ws_addr(wp_ff, csbs_pkg::SAVED_POINTER_SLOT);
			csbs_pkg::OP_W14, csbs_pkg::OP_R14: nxt_addr = ws_addr(wp_ff, csbs_pkg::SAVED_COUNTER_SLOT);
			csbs_pkg::OP_W15, csbs_pkg::OP_R15: nxt_addr = ws_addr(wp_ff, csbs_pkg::SAVED_STATUS_SLOT);
			default: nxt_addr = csbs_pkg::ZERO_ADDR;
		endcase
		case (stp.op)
			csbs_pkg::OP_W13: nxt_dout = old_wp_ff;
			csbs_pkg::OP_W14: nxt_dout = old_pc_ff;
			csbs_pkg::OP_W15: nxt_dout = old_st_ff;
			default: nxt_dout = csbs_pkg::RST_WORD;
		endcase
	end

	always_comb begin
		nxt_iws_idx = csbs_pkg::IDX_ZERO;
		nxt_iws_data = csbs_pkg::RST_WORD;
		case (stp.op)
			// copy of the main instruction register
			csbs_pkg::OP_IIR: begin
				nxt_iws_idx = csbs_pkg::IR_COPY_SLOT;
				nxt_iws_data = instruction_register_i;
			end
			// counter minus two on second-word trap
			csbs_pkg::OP_IPC2: begin
				nxt_iws_idx = csbs_pkg::SAVED_COUNTER_SLOT;
				nxt_iws_data = old_pc_ff - csbs_pkg::WORD_STEP;
			end
			// prefix flags with first opcode word
			csbs_pkg::OP_IWR3: begin
				nxt_iws_idx = csbs_pkg::PREFIX_SLOT;
				nxt_iws_data = first_word_i;
			end
			csbs_pkg::OP_I13: begin
				nxt_iws_idx = csbs_pkg::SAVED_POINTER_SLOT;
				nxt_iws_data = old_wp_ff;
			end
			csbs_pkg::OP_I14: begin
				nxt_iws_idx = csbs_pkg::SAVED_COUNTER_SLOT;
				nxt_iws_data = old_pc_ff;
			end
			csbs_pkg::OP_I15: begin
				nxt_iws_idx = csbs_pkg::SAVED_STATUS_SLOT;
				nxt_iws_data = old_st_ff;
			end
			default: nxt_iws_idx = csbs_pkg::IDX_ZERO;
		endcase
	end

	// ----------------------------------------------------------------
	// Context registers
	// ----------------------------------------------------------------
	// Read data is taken at the edge that closes the read cycle
	always_ff @(posedge clk_sys_i or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			cap_ff <= csbs_pkg::OP_NONE;
			wp_ff <= csbs_pkg::RST_WORD;
			pc_ff <= csbs_pkg::RST_WORD;
			st_ff <= csbs_pkg::RST_WORD;
		end else begin
			cap_ff <= is_rd ? stp.op : csbs_pkg::OP_NONE;
			if (idle_w && ctx_load_i && !start_w) begin
				wp_ff <= ctx_wp_i;
				pc_ff <= ctx_pc_i;
				st_ff <= ctx_st_i;
			end
			if (cap_ff == csbs_pkg::OP_VWP || cap_ff == csbs_pkg::OP_R13) begin
				wp_ff <= data_in_i;
			end
			if (cap_ff == csbs_pkg::OP_VPC || cap_ff == csbs_pkg::OP_R14) begin
				pc_ff <= data_in_i;
			end else if (stp.op == csbs_pkg::OP_IVEC) begin
				pc_ff <= macro_vec_pc_i;
			end
			if (cap_ff == csbs_pkg::OP_R15) begin
				st_ff <= data_in_i;
			end
		end
	end

	// Old context is frozen at entry; the second-word trap adjusts it once
	always_ff @(posedge clk_sys_i or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			old_wp_ff <= csbs_pkg::RST_WORD;
			old_pc_ff <= csbs_pkg::RST_WORD;
			old_st_ff <= csbs_pkg::RST_WORD;
		end else if (start_w) begin
			old_wp_ff <= wp_ff;
			old_pc_ff <= pc_ff;
			old_st_ff <= st_ff;
		end else if (stp.op == csbs_pkg::OP_IPC2 && trap_second_word_i) begin
			old_pc_ff <= nxt_iws_data;
		end
	end

	// ----------------------------------------------------------------
	// Registered outputs
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys_i or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			bus_status_o <= csbs_pkg::INTERNAL_CYCLE_CODE;
			addr_o <= csbs_pkg::ZERO_ADDR;
			data_out_o <= csbs_pkg::RST_WORD;
			rd_o <= 1'b0;
			wr_o <= 1'b0;
			bus_grant_o <= 1'b0;
			busy_o <= 1'b0;
		end else begin
			bus_status_o <= stp.code;
			addr_o <= nxt_addr;
			data_out_o <= nxt_dout;
			rd_o <= is_rd;
			wr_o <= is_wr;
			// partner may drive only while granted
			bus_grant_o <= (stp.code == csbs_pkg::BUS_GRANT_CODE);
			busy_o <= (eff_state != csbs_pkg::CSBS_IDLE);
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			iws_we_o <= 1'b0;
			iws_idx_o <= csbs_pkg::IDX_ZERO;
			iws_data_o <= csbs_pkg::RST_WORD;
			iws_flags_o <= 2'b00;
		end else begin
			iws_we_o <= is_iws;
			iws_idx_o <= nxt_iws_idx;
			iws_data_o <= nxt_iws_data;
			iws_flags_o <= (stp.op == csbs_pkg::OP_IWR3) ?
					{long_source_flag_i, long_dest_flag_i} : 2'b00;
		end
	end

	assign wp_o = wp_ff;
	assign pc_o = pc_ff;
	assign st_o = st_ff;

endmodule : csbs_sequencer

/* verification/csbs_seq_props.sv */
// Concurrent checks on the ports of the context switch bus sequencer.
// Assumes vector and trap data stay stable while busy_o is high.
module csbs_seq_props #(
	parameter logic [15:0] L2_VEC_ADDR = 16'h0008
) (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic arst_n_i,
	// Requests and trap data
	input wire logic int_req_i,
	input wire logic trap_req_i,
	input wire logic attached_present_i,
	input wire logic hold_return_i,
	input wire logic [15:0] vec_addr_i,
	input wire logic [15:0] instruction_register_i,
	// Bus and progress
	input wire logic [3:0] bus_status_o,
	input wire logic [15:0] addr_o,
	input wire logic rd_o,
	input wire logic wr_o,
	input wire logic bus_grant_o,
	input wire logic iws_we_o,
	input wire logic [3:0] iws_idx_o,
	input wire logic [15:0] iws_data_o,
	input wire logic busy_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// ----------------
	// Code decodes
	// ----------------
	wire logic c_aux = bus_status_o == csbs_pkg::INTERNAL_CYCLE_CODE;
	wire logic c_vec = bus_status_o == csbs_pkg::VECTOR_READ_CODE;
	wire logic c_ws = bus_status_o == csbs_pkg::WORKSPACE_ACCESS_CODE;
	wire logic c_fet = bus_status_o == csbs_pkg::OPCODE_FETCH_CODE;
	wire logic c_ptr = bus_status_o == csbs_pkg::POINTER_OUT_CODE;
	wire logic c_st = bus_status_o == csbs_pkg::STATUS_OUT_CODE;
	wire logic c_chk = bus_status_o == csbs_pkg::PRESENCE_CHECK_CODE;
	wire logic c_grant = bus_status_o == csbs_pkg::BUS_GRANT_CODE;
	wire logic int_go = !busy_o && int_req_i && !trap_req_i;
	wire logic trap_go = !busy_o && trap_req_i;
	wire logic mid_go = c_chk && !attached_present_i;
	wire logic att_go = c_chk && attached_present_i;

	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!arst_n_i);

	// ----------------
	// Sequences and assertions
	// ----------------
	sequence s_int_head;
		c_aux [*2] ##1 (c_st && addr_o == 16'h0000) ##1 (c_vec && rd_o && addr_o == vec_addr_i);
	endsequence
	sequence s_int_tail;
		c_aux [*2] ##1 (c_vec && rd_o && addr_o == vec_addr_i + 16'h0002) ##1 c_ptr
			##1 (c_ws && wr_o) [*3] ##1 (c_fet && rd_o) ##1 c_aux;
	endsequence
	sequence s_resume;
		(c_ws && rd_o && !wr_o) [*3] ##1 c_st ##1 (c_fet && rd_o) ##1 c_ptr;
	endsequence

	a_int_head: assert property (int_go |=> s_int_head)
		else $error("interrupt entry head wrong");
	a_int_tail: assert property (int_go |-> ##5 s_int_tail)
		else $error("interrupt entry tail wrong");
	a_trap_check: assert property (trap_go |=> c_aux ##1 c_chk)
		else $error("trap start wrong");
	a_macro_quiet: assert property (mid_go |=> (c_aux && !rd_o && !wr_o) [*8])
		else $error("internal trap shows bus activity");
	a_ir_copy: assert property (mid_go |-> ##2 (iws_we_o && iws_idx_o == 4'h5
		&& iws_data_o == instruction_register_i))
		else $error("instruction register copy missing");
	a_attach_head: assert property (att_go |=> c_aux [*2] ##1 (c_st && addr_o == 16'h0000)
		##1 (c_vec && rd_o && addr_o == L2_VEC_ADDR))
		else $error("hand-over head wrong");
	a_attach_save: assert property (att_go |-> ##5 c_aux [*3] ##1 c_ptr
		##1 (c_ws && wr_o) [*3] ##1 (c_grant && bus_grant_o))
		else $error("hand-over save wrong");
	a_grant_code: assert property (bus_grant_o == c_grant)
		else $error("grant flag and code disagree");
	a_hold_stays: assert property (bus_grant_o && !hold_return_i && !$past(hold_return_i)
		|=> bus_grant_o)
		else $error("hold left without return");
	a_hold_exit: assert property (bus_grant_o && hold_return_i |=> c_grant ##1 s_resume)
		else $error("return sequence wrong");
	a_strobe_codes: assert property ((rd_o || wr_o) |-> (c_vec || c_fet || c_ws)
		&& !(rd_o && wr_o))
		else $error("strobe on non-memory cycle");
	a_idle_quiet: assert property (!busy_o && !$past(busy_o) |-> c_aux && !rd_o && !wr_o
		&& !bus_grant_o && !iws_we_o)
		else $error("idle cycle not quiet");
endmodule : csbs_seq_props

bind csbs_sequencer csbs_seq_props #(.L2_VEC_ADDR(L2_VEC_ADDR)) u_props (.*);

/* verification/csbs_far_side.sv */
// Far side of the sequencer: word memory on the external bus and an attached processor.
// Assumes no wait states; read data is taken at the edge closing the read cycle.
module csbs_far_side (
	// Clock
	input wire logic clk_sys_i,
	// Bus from the sequencer
	input wire logic [3:0] bus_status_i,
	input wire logic [15:0] addr_i,
	input wire logic [15:0] data_out_i,
	input wire logic rd_i,
	input wire logic wr_i,
	input wire logic bus_grant_i,
	input wire logic [15:0] wp_i,
	// Attached processor behaviour
	input wire logic [3:0] hold_wait_i,
	input wire logic [15:0] ret_wp_i,
	input wire logic [15:0] ret_pc_i,
	input wire logic [15:0] ret_st_i,
	// Answers
	output logic [15:0] data_in_o,
	output logic hold_return_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] mem [0:65535];
	logic ret_ff = 1'b0;
	logic [15:0] last_ff = 16'h0000;
	logic [3:0] cnt_ff = 4'h0;
	logic done_ff = 1'b0;
	wire logic mem_cyc = bus_status_i == csbs_pkg::VECTOR_READ_CODE
		|| bus_status_i == csbs_pkg::WORKSPACE_ACCESS_CODE
		|| bus_status_i == csbs_pkg::OPCODE_FETCH_CODE;
	wire logic ret_now = bus_grant_i && !done_ff && cnt_ff == hold_wait_i;
	// Undriven data flips every cycle so stale data never passes for an answer
	assign data_in_o = (rd_i && mem_cyc) ? mem[addr_i] : ~last_ff;

	assign hold_return_o = ret_ff;

	always @(posedge clk_sys_i) begin
		last_ff <= data_in_o;
		if (wr_i && mem_cyc) begin
			mem[addr_i] <= data_out_i;
		end
		if (ret_now) begin
			mem[wp_i + 16'h001c] <= ret_pc_i;
			mem[wp_i + 16'h001e] <= ret_st_i;
			mem[wp_i + 16'h001a] <= ret_wp_i;
		end
		ret_ff <= ret_now;
		done_ff <= bus_grant_i && (done_ff || ret_now);
		cnt_ff <= bus_grant_i ? cnt_ff + 4'h1 : 4'h0;
	end
endmodule : csbs_far_side

/* verification/tb_context_switch_bus_sequencer.sv */
// Self-checking bench for the context switch bus sequencer.
// Assumes a far side with no wait states.
module tb_context_switch_bus_sequencer;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic int_req_i = 1'b0, trap_req_i = 1'b0, trap_second_word_i = 1'b0;
	logic attached_present_i = 1'b0, ctx_load_i = 1'b0;
	logic long_source_flag_i = 1'b0, long_dest_flag_i = 1'b0;
	logic [15:0] ctx_wp_i = 16'h0000, ctx_pc_i = 16'h0000, ctx_st_i = 16'h0000;
	logic [15:0] vec_addr_i = 16'h0000, instruction_register_i = 16'h0000;
	logic [15:0] first_word_i = 16'h0000, macro_vec_pc_i = 16'h0000;
	logic [3:0] hold_wait_i = 4'h0;
	logic [15:0] ret_wp_i = 16'h0000, ret_pc_i = 16'h0000, ret_st_i = 16'h0000;
	wire logic [15:0] data_in_i, addr_o, data_out_o, iws_data_o, wp_o, pc_o, st_o;
	wire logic [3:0] bus_status_o, iws_idx_o;
	wire logic [1:0] iws_flags_o;
	wire logic rd_o, wr_o, bus_grant_o, iws_we_o, busy_o, hold_return_i;
	int seed = 56222;
	int err_total = 0;
	int checks_done = 0;
	logic hold_seen = 1'b0;
	logic [21:0] iws_q[$];

	csbs_sequencer uut (.*);
	csbs_far_side u_far (.clk_sys_i, .bus_status_i(bus_status_o), .addr_i(addr_o),
		.data_out_i(data_out_o), .rd_i(rd_o), .wr_i(wr_o), .bus_grant_i(bus_grant_o),
		.wp_i(wp_o), .hold_wait_i, .ret_wp_i, .ret_pc_i, .ret_st_i, .data_in_o(data_in_i),
		.hold_return_o(hold_return_i));

	initial begin
		forever #50 clk_sys_i = ~clk_sys_i;
	end

	always @(posedge clk_sys_i) begin
		if (iws_we_o === 1'b1) begin
			iws_q.push_back({iws_flags_o, iws_idx_o, iws_data_o});
		end
	end

	// ----------------
	// Shared tasks
	// ----------------
	function automatic logic [15:0] rnd(input logic [15:0] m);
		rnd = 16'($random(seed)) & m;
	endfunction : rnd

	task automatic complete_run();
		if (err_total == 0 && checks_done > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : complete_run

	task automatic check(input logic ok, input string msg);
		checks_done++;
		if (ok !== 1'b1) begin
			err_total++;
			$display("Error at %0t: %s", $time, msg);
		end
	endtask : check

	// One machine cycle: check the bus, then wait for the edge
	task automatic step(input logic [3:0] c, input logic [15:0] a = 16'h0000,
			input logic r = 1'b0, input logic w = 1'b0, input logic [15:0] d = 16'h0000);
		#1;
		hold_seen = hold_return_i;
		check(bus_status_o === c && addr_o === a && rd_o === r && wr_o === w
			&& data_out_o === d && busy_o === 1'b1
			&& bus_grant_o === (c == csbs_pkg::BUS_GRANT_CODE), "bus cycle mismatch");
		@(posedge clk_sys_i);
		int_req_i <= 1'b0;
	endtask : step

	task automatic quiet(input int n);
		repeat (n) step(csbs_pkg::INTERNAL_CYCLE_CODE);
	endtask : quiet

	task automatic saves(input logic [15:0] b, input logic [15:0] x, y, z);
		step(csbs_pkg::WORKSPACE_ACCESS_CODE, b + 16'h001a, 1'b0, 1'b1, x);
		step(csbs_pkg::WORKSPACE_ACCESS_CODE, b + 16'h001c, 1'b0, 1'b1, y);
		step(csbs_pkg::WORKSPACE_ACCESS_CODE, b + 16'h001e, 1'b0, 1'b1, z);
	endtask : saves

	// An interrupt raised with a trap must lose
	task automatic start(input logic t, input logic i);
		@(posedge clk_sys_i);
		trap_req_i <= t;
		int_req_i <= i;
		@(posedge clk_sys_i);
		trap_req_i <= 1'b0;
		if (!t) begin
			int_req_i <= 1'b0;
		end
	endtask : start

	// ----------------
	// Main sequence
	// ----------------
	initial begin : main
		logic [15:0] owp, opc, ost, vec, ir, fw, nwp, npc, mpc, padj;
		logic [1:0] fl;
		logic sw;
		int kind;
		int n;
		logic [21:0] ex[$];
		repeat (20) @(posedge clk_sys_i);
		arst_n_i <= 1'b1;
		repeat (4) @(posedge clk_sys_i);
		for (int k = 0; k < 9; k++) begin
			kind = k % 3;
			sw = (k % 6) == 1;
			owp = 16'h8000 | rnd(16'h3f00);
			opc = rnd(16'hfffe);
			ost = rnd(16'hffff);
			vec = 16'h0100 | rnd(16'h00fc);
			ir = rnd(16'hffff);
			fw = rnd(16'hffff);
			mpc = rnd(16'hfffe);
			fl = 2'(rnd(16'h0003));
			nwp = 16'hc000 | rnd(16'h3f00);
			npc = rnd(16'hfffe);
			u_far.mem[vec] = nwp;
			u_far.mem[vec + 16'h0002] = npc;
			u_far.mem[16'h0008] = nwp;
			ctx_wp_i <= owp;
			ctx_pc_i <= opc;
			ctx_st_i <= ost;
			vec_addr_i <= vec;
			instruction_register_i <= ir;
			first_word_i <= fw;
			macro_vec_pc_i <= mpc;
			{long_source_flag_i, long_dest_flag_i} <= fl;
			trap_second_word_i <= sw;
			attached_present_i <= kind == 2;
			hold_wait_i <= (k == 2) ? 4'h0 : 4'(rnd(16'h0007));
			ret_wp_i <= 16'h4000 | rnd(16'h3f00);
			ret_pc_i <= rnd(16'hfffe);
			ret_st_i <= rnd(16'hffff);
			ctx_load_i <= 1'b1;
			@(posedge clk_sys_i);
			ctx_load_i <= 1'b0;
			iws_q.delete();
			if (kind == 0) begin
				start(1'b0, 1'b1);
				quiet(2);
				step(csbs_pkg::STATUS_OUT_CODE);
				step(csbs_pkg::VECTOR_READ_CODE, vec, 1'b1);
				quiet(2);
				step(csbs_pkg::VECTOR_READ_CODE, vec + 16'h0002, 1'b1);
				step(csbs_pkg::POINTER_OUT_CODE, nwp);
				saves(nwp, owp, opc, ost);
				step(csbs_pkg::OPCODE_FETCH_CODE, npc, 1'b1);
				quiet(1);
				check(wp_o === nwp && st_o === ost, "context after interrupt");
			end else begin
				start(1'b1, k >= 3);
				quiet(1);
				step(csbs_pkg::PRESENCE_CHECK_CODE);
			end
			if (kind == 1) begin
				quiet(12);
				padj = sw ? opc - 16'h0002 : opc;
				ex = {{2'b00, 4'h5, ir}};
				if (sw) begin
					ex.push_back({2'b00, 4'he, padj});
				end
				ex.push_back({fl, 4'h3, fw});
				ex.push_back({2'b00, 4'hd, owp});
				ex.push_back({2'b00, 4'he, padj});
				ex.push_back({2'b00, 4'hf, ost});
				check(iws_q.size() == ex.size(), "internal write count");
				foreach (ex[i]) begin
					check(iws_q[i] === ex[i], "internal workspace write");
				end
				check(pc_o === mpc, "internal store counter");
			end
			if (kind == 2) begin
				quiet(2);
				step(csbs_pkg::STATUS_OUT_CODE);
				step(csbs_pkg::VECTOR_READ_CODE, 16'h0008, 1'b1);
				quiet(3);
				step(csbs_pkg::POINTER_OUT_CODE, nwp);
				saves(nwp, owp, opc, ost);
				n = 0;
				do begin
					step(csbs_pkg::BUS_GRANT_CODE);
					n++;
				end while (hold_seen !== 1'b1 && n < 20);
				if (n >= 20) begin
					check(1'b0, "hold never returned");
					complete_run();
				end
				step(csbs_pkg::BUS_GRANT_CODE);
				step(csbs_pkg::WORKSPACE_ACCESS_CODE, nwp + 16'h001c, 1'b1);
				step(csbs_pkg::WORKSPACE_ACCESS_CODE, nwp + 16'h001e, 1'b1);
				step(csbs_pkg::WORKSPACE_ACCESS_CODE, nwp + 16'h001a, 1'b1);
				step(csbs_pkg::STATUS_OUT_CODE, ret_st_i);
				step(csbs_pkg::OPCODE_FETCH_CODE, ret_pc_i, 1'b1);
				step(csbs_pkg::POINTER_OUT_CODE, ret_wp_i);
				check(wp_o === ret_wp_i && st_o === ret_st_i, "context after return");
			end
			repeat (2) @(posedge clk_sys_i);
		end
		complete_run();
	end
endmodule : tb_context_switch_bus_sequencer
